/* File: adm_core.sv */
// Output demux, strobe forwarding, sleep and trim sequencing of the converter.
// Assumes the sample clock, code, range and strap pins are asynchronous to clk,
// and that the sample clock is much slower than clk (at least 8 clk per period).
//
// Contract
// - A sample is taken at each falling edge of the sample clock while sleep is not requested.
// - Results are split one-to-two onto two buses at half rate.
// - Consecutive samples alternate between the buses in time order.
// - Latency is eight cycles on the early bus, seven on the late bus.
// - Codes are 8-bit offset binary, all zeros most negative.
// - Edge select high: data change on strobe rising edge; low: falling.
// - While sleep is requested the converter stops; otherwise it converts.
// - Trigger low ten cycles then high ten cycles starts a trim.
// - After power-up wait the strap-selected count, then trim automatically.
// - Early bus carries the first sample of a pair, late bus the second.
// - Trim-in-progress is high exactly while a trim runs.
// - Both buses change together with the forwarded strobe.
// - Out-of-range flag follows the comparator for the output pair.
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module adm_core #(
   parameter logic [adm_pkg::ADM_CNT_W-1:0] DLY_SHORT = adm_pkg::ADM_DLY_SHORT,
   parameter logic [adm_pkg::ADM_CNT_W-1:0] DLY_LONG = adm_pkg::ADM_DLY_LONG,
   parameter logic [adm_pkg::ADM_CNT_W-1:0] TRIM_LEN = adm_pkg::ADM_TRIM_LEN
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic sample_clk,
   input wire logic [adm_pkg::ADM_CODE_W-1:0] quant_code,
   input wire logic range_exceeded,
   input wire logic transition_edge_select,
   input wire logic sleep_request,
   input wire logic trim_trigger,
   input wire logic trim_start_delay_select,
   input wire logic [adm_pkg::ADM_ADDR_W-1:0] reg_addr,
   input wire logic [adm_pkg::ADM_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [adm_pkg::ADM_DATA_W-1:0] reg_rdata,
   output logic [adm_pkg::ADM_CODE_W-1:0] early_sample_bus,
   output logic [adm_pkg::ADM_CODE_W-1:0] late_sample_bus,
   output logic output_data_strobe,
   output logic out_of_range,
   output logic trim_in_progress,
   output logic irq
);
   adm_pkg::adm_core_t q;
   adm_pkg::adm_core_t d;
   logic fall;
   logic take;
   logic trig_done;
   logic trim_end;
   adm_pkg::adm_sample_t fresh;
   logic [adm_pkg::ADM_CNT_W-1:0] cnt_inc;
   logic [adm_pkg::ADM_CNT_W-1:0] wait_target;

   always_comb begin
      d = q;
      fresh = '0;
      trig_done = 1'b0;
      trim_end = 1'b0;
      cnt_inc = q.cnt + 24'h000001;
      wait_target = q.dly_sync[1] ? DLY_LONG : DLY_SHORT;
      d.clk_sync = {q.clk_sync[0], sample_clk};
      d.sel_sync = {q.sel_sync[0], transition_edge_select};
      d.sleep_sync = {q.sleep_sync[0], sleep_request};
      d.trig_sync = {q.trig_sync[0], trim_trigger};
      d.dly_sync = {q.dly_sync[0], trim_start_delay_select};
      d.ovr_sync = {q.ovr_sync[0], range_exceeded};
      d.code_sync = {q.code_sync[0], quant_code};
      d.clk_prev = q.clk_sync[1];
      fall = q.clk_prev & ~q.clk_sync[1];
      take = fall & ~q.sleep_sync[1];
      fresh.code = q.code_sync[1] ^ adm_pkg::ADM_MSB_FLIP;
      fresh.ovr = q.ovr_sync[1];
      if (q.sleep_sync[1]) begin
         d.fill = 4'h0;
         d.phase = 1'b0;
      end else if (take) begin
         d.hist = {q.hist[adm_pkg::ADM_HIST_N-2:0], fresh};
         d.phase = ~q.phase;
         if (q.fill != adm_pkg::ADM_FILL_MAX) begin
            d.fill = q.fill + 4'h1;
         end
         if (q.fill >= adm_pkg::ADM_FILL_FULL) begin
            if (!q.phase) begin
               d.early = q.hist[7].code;
               d.late = q.hist[6].code;
               d.ovr_out = q.hist[7].ovr | q.hist[6].ovr;
               d.strobe = q.sel_sync[1];
               d.pairs = q.pairs + 16'h0001;
            end else begin
               d.strobe = ~q.sel_sync[1];
            end
         end
      end
      if (fall) begin
         if (!q.trig_sync[1]) begin
            d.high_cnt = 4'h0;
            // A low after some highs opens a new low run; a stale full count would skip it
            if (q.high_cnt != 4'h0) begin
               d.low_cnt = 4'h1;
            end else if (q.low_cnt != adm_pkg::ADM_TRIG_MIN) begin
               d.low_cnt = q.low_cnt + 4'h1;
            end
         end else if (q.low_cnt == adm_pkg::ADM_TRIG_MIN) begin
            d.high_cnt = q.high_cnt + 4'h1;
            if (d.high_cnt == adm_pkg::ADM_TRIG_MIN) begin
               trig_done = 1'b1;
               d.low_cnt = 4'h0;
               d.high_cnt = 4'h0;
            end
         end else begin
            d.low_cnt = 4'h0;
         end
      end
      unique case (q.mode)
         adm_pkg::ADM_WAIT: begin
            if (fall) begin
               d.cnt = cnt_inc;
               if (cnt_inc >= wait_target) begin
                  d.mode = adm_pkg::ADM_TRIM;
                  d.cnt = '0;
               end
            end
         end
         adm_pkg::ADM_IDLE: begin
            if (trig_done) begin
               d.mode = adm_pkg::ADM_TRIM;
               d.cnt = '0;
            end
         end
         adm_pkg::ADM_TRIM: begin
            if (fall) begin
               d.cnt = cnt_inc;
               if (cnt_inc >= TRIM_LEN) begin
                  trim_end = 1'b1;
                  d.mode = adm_pkg::ADM_IDLE;
                  d.cnt = '0;
               end
            end
         end
         default: begin
            d.mode = adm_pkg::ADM_IDLE;
         end
      endcase
      d.busy = (d.mode == adm_pkg::ADM_TRIM);
      if (reg_wr && reg_addr == adm_pkg::ADM_REG_MASK) begin
         d.mask = reg_wdata[2:0];
      end
      d.rdata = '0;
      if (reg_rd) begin
         unique case (reg_addr)
            adm_pkg::ADM_REG_STATUS: d.rdata = {13'h0000, q.status};
            adm_pkg::ADM_REG_MASK: d.rdata = {13'h0000, q.mask};
            adm_pkg::ADM_REG_PAIRS: d.rdata = q.pairs;
            adm_pkg::ADM_REG_PINS: d.rdata = {12'h000, q.sleep_sync[1], q.sel_sync[1],
                                              q.dly_sync[1], q.busy};
            default: d.rdata = '0;
         endcase
      end
      // Clear on read first so a same-cycle event still lands
      if (reg_rd && reg_addr == adm_pkg::ADM_REG_STATUS) begin
         d.status = 3'h0;
      end
      if (trim_end) begin
         d.status[adm_pkg::ADM_ST_DONE] = 1'b1;
      end
      if (take && q.ovr_sync[1]) begin
         d.status[adm_pkg::ADM_ST_OVR] = 1'b1;
      end
      if (trig_done && q.mode != adm_pkg::ADM_IDLE) begin
         d.status[adm_pkg::ADM_ST_IGN] = 1'b1;
      end
      d.irq = |(d.status & d.mask);
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
         q.mode <= adm_pkg::ADM_WAIT;
         q.mask <= adm_pkg::ADM_MASK_RST;
      end else begin
         q <= d;
      end
   end

   assign reg_rdata = q.rdata;
   assign early_sample_bus = q.early;
   assign late_sample_bus = q.late;
   assign output_data_strobe = q.strobe;
   assign out_of_range = q.ovr_out;
   assign trim_in_progress = q.busy;
   assign irq = q.irq;

   sequence s_pair_take;
      take && !q.phase && q.fill >= adm_pkg::ADM_FILL_FULL;
   endsequence

   sequence s_trig_accept;
      trig_done && q.mode == adm_pkg::ADM_IDLE;
   endsequence

   chk_take_code: assert property (@(posedge clk) disable iff (!resetn)
      take |=> q.hist[0].code == ($past(q.code_sync[1]) ^ adm_pkg::ADM_MSB_FLIP))
      else $error("sample not taken as offset binary at falling edge");

   chk_bus_quiet: assert property (@(posedge clk) disable iff (!resetn)
      !take |=> $stable(early_sample_bus) && $stable(late_sample_bus))
      else $error("bus changed without a sample edge");

   chk_pair_order: assert property (@(posedge clk) disable iff (!resetn)
      s_pair_take |=> early_sample_bus == $past(q.hist[7].code)
                      && late_sample_bus == $past(q.hist[6].code))
      else $error("pair order or latency wrong");

   chk_latency_depth: assert property (@(posedge clk) disable iff (!resetn)
      s_pair_take |=> q.fill == adm_pkg::ADM_FILL_MAX && early_sample_bus == q.hist[8].code
                      && late_sample_bus == q.hist[7].code)
      else $error("latency not eight and seven");

   chk_strobe_edge: assert property (@(posedge clk) disable iff (!resetn)
      s_pair_take |=> output_data_strobe == $past(q.sel_sync[1]))
      else $error("strobe edge does not match edge select");

   chk_strobe_mid: assert property (@(posedge clk) disable iff (!resetn)
      take && q.phase && q.fill >= adm_pkg::ADM_FILL_FULL
      |=> output_data_strobe == !$past(q.sel_sync[1]) && $stable(early_sample_bus))
      else $error("strobe mid edge wrong");

   chk_sleep_hold: assert property (@(posedge clk) disable iff (!resetn)
      q.sleep_sync[1] |=> q.fill == 4'h0 && $stable(early_sample_bus)
                          && $stable(output_data_strobe))
      else $error("outputs moved during sleep");

   chk_trig_start: assert property (@(posedge clk) disable iff (!resetn)
      s_trig_accept |=> trim_in_progress ##1 trim_in_progress)
      else $error("trigger pattern did not start trim");

   chk_trig_ignore: assert property (@(posedge clk) disable iff (!resetn)
      trig_done && q.mode == adm_pkg::ADM_TRIM |=> q.status[adm_pkg::ADM_ST_IGN]
                                                   && q.cnt == $past(q.cnt) + 24'h000001
                                                   || q.mode == adm_pkg::ADM_IDLE)
      else $error("trigger restarted running trim");

   chk_busy_level: assert property (@(posedge clk) disable iff (!resetn)
      trim_in_progress == (q.mode == adm_pkg::ADM_TRIM))
      else $error("trim flag not matching trim state");

   chk_wait_exit: assert property (@(posedge clk) disable iff (!resetn)
      q.mode == adm_pkg::ADM_WAIT ##1 q.mode == adm_pkg::ADM_TRIM
      |-> $past(q.cnt) + 24'h000001 >= $past(wait_target))
      else $error("auto trim started before delay");

   chk_range_flag: assert property (@(posedge clk) disable iff (!resetn)
      s_pair_take |=> out_of_range == ($past(q.hist[7].ovr) | $past(q.hist[6].ovr)))
      else $error("range flag not aligned to pair");

   chk_irq_level: assert property (@(posedge clk) disable iff (!resetn)
      ##1 irq == |(q.status & q.mask))
      else $error("interrupt not following masked status");

   // Wake from sleep: one cycle asleep, then awake
   sequence s_wake;
      q.sleep_sync[1] ##1 !q.sleep_sync[1];
   endsequence

   chk_wake_phase: assert property (@(posedge clk) disable iff (!resetn)
      s_wake |-> !q.phase && q.fill == 4'h0)
      else $error("first sample after wake not first of pair");

   chk_pair_count: assert property (@(posedge clk) disable iff (!resetn)
      s_pair_take |=> q.pairs == $past(q.pairs) + 16'h0001)
      else $error("pair count not advanced on pair output");

   chk_fill_bound: assert property (@(posedge clk) disable iff (!resetn)
      q.fill <= adm_pkg::ADM_FILL_MAX)
      else $error("pipeline fill beyond history depth");

   // Mid edge moves only the strobe, so the receiver latches a settled pair
   chk_mid_late: assert property (@(posedge clk) disable iff (!resetn)
      take && q.phase && q.fill >= adm_pkg::ADM_FILL_FULL
      |=> $stable(late_sample_bus) && $stable(out_of_range))
      else $error("late bus or range flag moved at mid edge");

   chk_trig_source: assert property (@(posedge clk) disable iff (!resetn)
      trig_done |-> fall && q.trig_sync[1] && q.low_cnt == adm_pkg::ADM_TRIG_MIN
                    && q.high_cnt == adm_pkg::ADM_TRIG_MIN - 4'h1)
      else $error("trigger accepted without full pattern");

   chk_low_restart: assert property (@(posedge clk) disable iff (!resetn)
      fall && !q.trig_sync[1] && q.high_cnt != 4'h0 |=> q.low_cnt == 4'h1)
      else $error("low run not restarted after highs");

   chk_wait_hold: assert property (@(posedge clk) disable iff (!resetn)
      q.mode == adm_pkg::ADM_WAIT && !fall
      |=> q.mode == adm_pkg::ADM_WAIT && $stable(q.cnt))
      else $error("power-up wait moved without a sample edge");

   chk_trim_stay: assert property (@(posedge clk) disable iff (!resetn)
      trim_in_progress && !trim_end |=> trim_in_progress)
      else $error("trim flag dropped before trim end");

   chk_idle_stay: assert property (@(posedge clk) disable iff (!resetn)
      q.mode == adm_pkg::ADM_IDLE && !trig_done |=> !trim_in_progress)
      else $error("trim flag rose without a trigger");

   chk_done_flag: assert property (@(posedge clk) disable iff (!resetn)
      trim_end |=> q.status[adm_pkg::ADM_ST_DONE] && !trim_in_progress)
      else $error("trim end not flagged");

   chk_ovr_event: assert property (@(posedge clk) disable iff (!resetn)
      take && q.ovr_sync[1] |=> q.status[adm_pkg::ADM_ST_OVR])
      else $error("out-of-range sample not flagged");

   chk_ign_event: assert property (@(posedge clk) disable iff (!resetn)
      trig_done && q.mode != adm_pkg::ADM_IDLE |=> q.status[adm_pkg::ADM_ST_IGN])
      else $error("ignored trigger not flagged");

   // Register side bookkeeping
   chk_status_read: assert property (@(posedge clk) disable iff (!resetn)
      reg_rd && reg_addr == adm_pkg::ADM_REG_STATUS
      |=> reg_rdata == {13'h0000, $past(q.status)})
      else $error("status read returned wrong value");

   chk_pins_read: assert property (@(posedge clk) disable iff (!resetn)
      reg_rd && reg_addr == adm_pkg::ADM_REG_PINS |=> reg_rdata[0] == $past(q.busy))
      else $error("pin read does not show trim state");

   chk_mask_write: assert property (@(posedge clk) disable iff (!resetn)
      reg_wr && reg_addr == adm_pkg::ADM_REG_MASK |=> q.mask == $past(reg_wdata[2:0]))
      else $error("mask write did not land");

   chk_rdata_idle: assert property (@(posedge clk) disable iff (!resetn)
      !reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data not zero outside a read");

   chk_irq_masked: assert property (@(posedge clk) disable iff (!resetn)
      q.mask == 3'h0 && !reg_wr |=> !irq)
      else $error("interrupt raised with all events masked");
endmodule : adm_core
`default_nettype wire

/* File: adm_core_bench.sv */
// Bench for adm_core: free sample clock, pin stimulus and register port,
// with the receiver model's captures judged against expected pairs.
`timescale 1ns/1ps
`default_nettype none
module adm_core_bench;
   localparam logic [23:0] T_SHORT = 24'h000004;
   localparam logic [23:0] T_TRIM = 24'h000028;
   localparam logic [23:0] T_LONG = 24'h000008;
   logic clk, resetn, sample_clk, range_exceeded, edge_sel, sleep_request, trim_trigger;
   logic dly_sel, reg_wr, reg_rd, strobe, oor, busy, irq, sclk_q, rng_on, cap_oor;
   logic [7:0] quant_code, early, late, cap_early, cap_late;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   int bad_count, num_checks, n_fall, cap_cnt, skew_errs;

   adm_core #(.DLY_SHORT(T_SHORT), .DLY_LONG(T_LONG), .TRIM_LEN(T_TRIM)) dut (
      .clk(clk), .resetn(resetn), .sample_clk(sample_clk), .quant_code(quant_code),
      .range_exceeded(range_exceeded), .transition_edge_select(edge_sel),
      .sleep_request(sleep_request), .trim_trigger(trim_trigger),
      .trim_start_delay_select(dly_sel), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .early_sample_bus(early),
      .late_sample_bus(late), .output_data_strobe(strobe), .out_of_range(oor),
      .trim_in_progress(busy), .irq(irq));
   adm_receiver rx (.clk(clk), .edge_sel(edge_sel), .strobe(strobe), .early_bus(early),
      .late_bus(late), .oor(oor), .busy(busy), .sleeping(sleep_request),
      .cap_early(cap_early), .cap_late(cap_late), .cap_oor(cap_oor), .cap_cnt(cap_cnt),
      .skew_errs(skew_errs));

   // Both extremes of the code range appear in every run
   function automatic logic [7:0] code_of(input int n);
      if (n % 8 == 0) return 8'h80;
      if (n % 8 == 1) return 8'h7F;
      return 8'(n * 37 + 5);
   endfunction : code_of
   function automatic logic rng_of(input int n);
      return n % 7 == 3;
   endfunction : rng_of

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Unrelated phase to clk, so no fall lands on a clk edge
   initial begin
      sample_clk = 1'b1;
      #3.3;
      forever #40 sample_clk = ~sample_clk;
   end
   always @(negedge sample_clk) n_fall++;
   // code changes at rise, stable for the fall
   always @(posedge clk) begin
      sclk_q <= sample_clk;
      if (sample_clk && !sclk_q) begin
         quant_code <= code_of(n_fall);
         range_exceeded <= rng_on && rng_of(n_fall);
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge clk) reg_wr <= 1'b0;
   endtask : reg_write
   task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge clk) reg_rd <= 1'b0;
      @(negedge clk) d = reg_rdata;
   endtask : reg_read
   task automatic hold_trig(input logic v, input int n);
      @(posedge sample_clk);
      @(posedge clk) trim_trigger <= v;
      repeat (n) @(negedge sample_clk);
   endtask : hold_trig
   task automatic wait_busy(input logic lvl, input int lim);
      for (int i = 0; i < lim && busy !== lvl; i++) @(negedge clk);
      check(16'(busy), 16'(lvl));
   endtask : wait_busy

   task automatic t_powerup();
      int f0;
      logic [15:0] v;
      f0 = n_fall;
      reg_read(adm_pkg::ADM_REG_MASK, v);
      check(v, 16'h0000);
      reg_write(adm_pkg::ADM_REG_MASK, 16'h0007);
      reg_read(4'hF, v);
      check(v, 16'h0000);
      wait_busy(1'b1, 400);
      check(16'(n_fall - f0 == T_SHORT || n_fall - f0 == T_SHORT + 1), 16'h0001);
      f0 = n_fall;
      wait_busy(1'b0, 800);
      check(16'(n_fall - f0), 16'(T_TRIM));
      repeat (2) @(negedge clk);
      check(16'(irq), 16'h0001);
      reg_read(adm_pkg::ADM_REG_STATUS, v);
      check(v, 16'h0001);
      repeat (2) @(negedge clk);
      check(16'(irq), 16'h0000);
   endtask : t_powerup

   task automatic t_trigger();
      logic [15:0] v;
      reg_write(adm_pkg::ADM_REG_MASK, 16'h0000);
      hold_trig(1'b0, 9);
      hold_trig(1'b1, 10);
      repeat (6) @(negedge clk);
      check(16'(busy), 16'h0000);
      hold_trig(1'b0, 10);
      hold_trig(1'b1, 10);
      repeat (6) @(negedge clk);
      check(16'(busy), 16'h0001);
      hold_trig(1'b0, 10);
      hold_trig(1'b1, 10);
      wait_busy(1'b0, 800);
      repeat (2) @(negedge clk);
      check(16'(irq), 16'h0000);
      reg_read(adm_pkg::ADM_REG_STATUS, v);
      check(v, 16'h0005);
   endtask : t_trigger

   task automatic t_stream(input logic sel);
      int base, c0, s0;
      logic [7:0] q0, q1;
      logic [15:0] v;
      @(posedge clk) sleep_request <= 1'b1;
      repeat (3) @(negedge sample_clk);
      @(posedge clk) {edge_sel, rng_on} <= {sel, 1'b1};
      @(negedge clk) v = {early, late};
      repeat (4) @(negedge sample_clk);
      check({early, late}, v);
      reg_read(adm_pkg::ADM_REG_PINS, v);
      check(v, {12'h000, 1'b1, sel, 2'b00});
      @(posedge sample_clk);
      @(posedge clk) sleep_request <= 1'b0;
      base = n_fall;
      c0 = cap_cnt;
      for (int p = 0; p < 6; p++) begin
         for (int i = 0; i < 600 && cap_cnt == c0 + p; i++) @(negedge clk);
         if (p == 0) s0 = skew_errs;
         q0 = code_of(base + 2 * p) + 8'h80;
         q1 = code_of(base + 2 * p + 1) + 8'h80;
         check(16'(n_fall - base), 16'(2 * p + 10));
         check({cap_early, cap_late}, {q0, q1});
         check(16'(cap_oor), 16'(rng_of(base + 2 * p) || rng_of(base + 2 * p + 1)));
         check(16'(strobe), 16'(!sel));
      end
      check(16'(skew_errs - s0), 16'h0000);
      reg_read(adm_pkg::ADM_REG_STATUS, v);
      check(v & 16'h0002, 16'h0002);
   endtask : t_stream

   // Mid-run reset with the long power-up wait selected
   task automatic t_reset_long();
      int f0;
      logic [15:0] v;
      @(posedge clk) {resetn, dly_sel} <= 2'b01;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      f0 = n_fall;
      @(negedge clk);
      check({early, late}, 16'h0000);
      check(16'(busy), 16'h0000);
      reg_read(adm_pkg::ADM_REG_PAIRS, v);
      check(v, 16'h0000);
      reg_read(adm_pkg::ADM_REG_PINS, v);
      check(v, 16'h0002);
      wait_busy(1'b1, 400);
      check(16'(n_fall - f0 == T_LONG || n_fall - f0 == T_LONG + 1), 16'h0001);
   endtask : t_reset_long

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : print_verdict

   initial begin
      {resetn, edge_sel, sleep_request, dly_sel, reg_wr, reg_rd, rng_on} = 7'h00;
      {trim_trigger, sclk_q, range_exceeded, quant_code} = {3'b100, 8'h00};
      {reg_addr, reg_wdata} = 20'h00000;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      t_powerup();
      t_trigger();
      t_stream(1'b1);
      t_stream(1'b0);
      t_reset_long();
      print_verdict();
   end
   // Tests need about 15 us; a hang is cut well after that
   initial begin
      #200000;
      bad_count++;
      $display("ERROR %0t: watchdog expired", $time);
      print_verdict();
   end
endmodule : adm_core_bench
`default_nettype wire

/* File: adm_pkg.sv */
// Package for the converter output demux and trim control.
// Assumes one 200 MHz system clock; all pins but the register port arrive asynchronous to it.
package adm_pkg;
   localparam int unsigned ADM_CODE_W = 8;
   localparam int unsigned ADM_DATA_W = 16;
   localparam int unsigned ADM_ADDR_W = 4;
   localparam int unsigned ADM_CNT_W = 24;
   localparam int unsigned ADM_HIST_N = 9;
   localparam logic [3:0] ADM_FILL_FULL = 4'h8;
   localparam logic [3:0] ADM_FILL_MAX = 4'h9;
   localparam logic [7:0] ADM_MSB_FLIP = 8'h80;
   localparam logic [3:0] ADM_TRIG_MIN = 4'hA;
   localparam real ADM_CLK_NS = 5.0;
   localparam real ADM_LINK_NS = 80.0;
   localparam int unsigned ADM_LINK_CYC = int'(ADM_LINK_NS / ADM_CLK_NS);
   localparam logic [ADM_ADDR_W-1:0] ADM_REG_STATUS = 4'h0;
   localparam logic [ADM_ADDR_W-1:0] ADM_REG_MASK = 4'h1;
   localparam logic [ADM_ADDR_W-1:0] ADM_REG_PAIRS = 4'h2;
   localparam logic [ADM_ADDR_W-1:0] ADM_REG_PINS = 4'h3;
   localparam int unsigned ADM_ST_DONE = 0;
   localparam int unsigned ADM_ST_OVR = 1;
   localparam int unsigned ADM_ST_IGN = 2;
   localparam logic [2:0] ADM_MASK_RST = 3'h0;
   localparam logic [ADM_CNT_W-1:0] ADM_DLY_SHORT = 24'h000400;
   localparam logic [ADM_CNT_W-1:0] ADM_DLY_LONG = 24'h010000;
   localparam logic [ADM_CNT_W-1:0] ADM_TRIM_LEN = 24'h002000;

   typedef enum logic [1:0] {
      ADM_WAIT,
      ADM_IDLE,
      ADM_TRIM
   } adm_mode_t;

   typedef struct packed {
      logic ovr;
      logic [ADM_CODE_W-1:0] code;
   } adm_sample_t;

   typedef struct packed {
      logic [1:0] clk_sync;
      logic clk_prev;
      logic [1:0] sel_sync;
      logic [1:0] sleep_sync;
      logic [1:0] trig_sync;
      logic [1:0] dly_sync;
      logic [1:0] ovr_sync;
      logic [1:0][ADM_CODE_W-1:0] code_sync;
      adm_sample_t [ADM_HIST_N-1:0] hist;
      logic [3:0] fill;
      logic phase;
      logic [ADM_CODE_W-1:0] early;
      logic [ADM_CODE_W-1:0] late;
      logic strobe;
      logic ovr_out;
      adm_mode_t mode;
      logic [ADM_CNT_W-1:0] cnt;
      logic [3:0] low_cnt;
      logic [3:0] high_cnt;
      logic busy;
      logic [2:0] status;
      logic [2:0] mask;
      logic irq;
      logic [ADM_DATA_W-1:0] rdata;
      logic [ADM_DATA_W-1:0] pairs;
   } adm_core_t;
endpackage : adm_pkg

/* File: adm_receiver.sv */
// Receiver model: latches both output buses on the strobe edge away from the data change.
// Assumes it runs on the fast system clock, far above the strobe rate.
`timescale 1ns/1ps
`default_nettype none
module adm_receiver (
   input wire logic clk,
   input wire logic edge_sel,
   input wire logic strobe,
   input wire logic [adm_pkg::ADM_CODE_W-1:0] early_bus,
   input wire logic [adm_pkg::ADM_CODE_W-1:0] late_bus,
   input wire logic oor,
   input wire logic busy,
   input wire logic sleeping,
   output logic [adm_pkg::ADM_CODE_W-1:0] cap_early,
   output logic [adm_pkg::ADM_CODE_W-1:0] cap_late,
   output logic cap_oor,
   output var int cap_cnt,
   output var int skew_errs
);
   logic strobe_q = 1'b0;
   logic [15:0] bus_q = 16'h0000;
   initial begin
      cap_early = 8'h00;
      cap_late = 8'h00;
      cap_oor = 1'b0;
      cap_cnt = 0;
      skew_errs = 0;
   end
   always @(posedge clk) begin
      strobe_q <= strobe;
      bus_q <= {early_bus, late_bus};
      // data move only on chosen edge
      if ({early_bus, late_bus} != bus_q && !(strobe != strobe_q && strobe == edge_sel)) begin
         skew_errs <= skew_errs + 1;
      end
      if (strobe != strobe_q && strobe != edge_sel && !busy && !sleeping) begin
         cap_early <= early_bus;
         cap_late <= late_bus;
         cap_oor <= oor;
         cap_cnt <= cap_cnt + 1;
      end
   end
endmodule : adm_receiver
`default_nettype wire
